// >>> design/srh_hub.sv
// shared resource hub: window scheduler, pin combiner, system counter
//
// What this block does
// - Index 0..15 of a core's special register array selects its registers.
// - Exclusive access granted to one core at a time, cores 0..7 wrapping.
// - Scheduler and its shared bus step at half the system clock.
// - Every core gets exactly one window per 16 system clock cycles.
// - Shared instruction waits for its window, then completes in 8 cycles.
// - Wait is 0..15 cycles, so total latency is 8..23 cycles.
// - Clock, identity, launch, halt, generic, lock, memory ops use windows.
// - Ordinary instructions take 4 cycles, one fits between shared ones.
// - One core's shared instruction never stalls or delays another core.
// - Thirty-two pins, usable by any core without arbitration.
// - Each core owns a private 32-bit direction and output register.
// - Pin direction is the OR of all running cores' direction registers.
// - Pin output is OR over cores of (counters|video|output) AND direction.
// - Direction bit 1 makes the pin an output, 0 an input.
// - A shut-down core has direction and outputs forced to zero.
// - Input view is the pins through two sync flops; each read returns levels two cycles old.
// - One global 32-bit counter, plus one per cycle, not writable.
// - All cores read the counter at once through their counter view.
// - The counter starts at zero at power-up and is never cleared by reset.
// - Rotation continues through all eight slots whether cores run or not.
// - Top sixteen local locations are the counter, pin and peripheral regs.
`timescale 1ns/1ps
module srh_hub
   import srh_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // cores
   input wire logic [NCORE-1:0] core_run_i,
   input wire srh_req_s [NCORE-1:0] core_req_i,
   input wire srh_pinsrc_s [NCORE-1:0] core_pinsrc_i,
   output logic [NCORE-1:0] core_grant_o,
   output logic [NCORE-1:0] core_done_o,
   output logic [NCORE-1:0] core_busy_o,
   // scheduler view
   output logic hub_en_o,
   output logic [CORE_W-1:0] hub_slot_o,
   output logic [CNT_W-1:0] sys_count_o,
   // pins
   input wire logic [NPIN-1:0] pin_i,
   output logic [NPIN-1:0] pin_o,
   output logic [NPIN-1:0] pin_oe_n_o
);

   // ------------------------------------------------------------
   // system counter
   // ------------------------------------------------------------
   // power-up value only, never touched by reset
   logic [CNT_W-1:0] sys_count = '0;

   always_ff @(posedge clk_i) begin
      sys_count <= sys_count + 1'b1;
   end

   always_ff @(posedge clk_i) begin
      sys_count_o <= sys_count + 1'b1;
   end

   // ------------------------------------------------------------
   // rotation phase and half-rate enable
   // ------------------------------------------------------------
   logic [PHASE_W-1:0] phase;
   logic [PHASE_W-1:0] next_phase;

   assign next_phase = (phase == ROT_LAST) ? '0 : phase + 1'b1;

   // no dependence on core_run_i: timing stays fixed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase <= '0;
         hub_en_o <= 1'b1;
         hub_slot_o <= '0;
      end else begin
         phase <= next_phase;
         hub_en_o <= ~next_phase[0];
         hub_slot_o <= next_phase[PHASE_W-1:1];
      end
   end

   // ------------------------------------------------------------
   // per-core shared instruction sequencing
   // ------------------------------------------------------------
   srh_state_e state [NCORE];
   logic [PHASE_W-1:0] run_cnt [NCORE];

   for (genvar k = 0; k < NCORE; k++) begin : g_core
      localparam logic [PHASE_W-1:0] WIN =
         PHASE_W'(k * int'(SLOT_CYC));
      logic at_win;
      assign at_win = (phase == WIN);

      // each core runs its own machine, no cross terms between cores
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            state[k] <= ST_IDLE;
            run_cnt[k] <= '0;
            core_grant_o[k] <= 1'b0;
            core_done_o[k] <= 1'b0;
            core_busy_o[k] <= 1'b0;
         end else begin
            core_grant_o[k] <= 1'b0;
            core_done_o[k] <= 1'b0;
            unique case (state[k])
               ST_IDLE: begin
                  run_cnt[k] <= '0;
                  if (core_req_i[k].valid) begin
                     core_busy_o[k] <= 1'b1;
                     if (core_req_i[k].op == OP_PLAIN) begin
                        state[k] <= ST_PLAIN;
                     end else if (at_win) begin
                        state[k] <= ST_HUB;
                        core_grant_o[k] <= 1'b1;
                     end else begin
                        state[k] <= ST_WAIT;
                     end
                  end
               end
               ST_WAIT: begin
                  if (at_win) begin
                     state[k] <= ST_HUB;
                     core_grant_o[k] <= 1'b1;
                  end
               end
               ST_HUB: begin
                  run_cnt[k] <= run_cnt[k] + 1'b1;
                  if (run_cnt[k] == HUB_EXEC_CYC - 1'b1) begin
                     state[k] <= ST_IDLE;
                     core_done_o[k] <= 1'b1;
                     core_busy_o[k] <= 1'b0;
                  end
               end
               ST_PLAIN: begin
                  run_cnt[k] <= run_cnt[k] + 1'b1;
                  if (run_cnt[k] == PLAIN_EXEC_CYC - 1'b1) begin
                     state[k] <= ST_IDLE;
                     core_done_o[k] <= 1'b1;
                     core_busy_o[k] <= 1'b0;
                  end
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   logic [CORE_W-1:0] a_core;
   logic [3:0] a_idx;
   logic a_bad;
   logic apb_wr;

   assign a_core = paddr_i[CORE_LSB +: CORE_W];
   assign a_idx = paddr_i[IDX_LSB +: 4];
   assign a_bad = (paddr_i[ADDR_W-1:MAP_TOP] != '0) ||
                  (paddr_i[IDX_LSB-1:0] != '0);
   assign apb_wr = psel_i && penable_i && pready_o && pwrite_i && !a_bad;

   // ------------------------------------------------------------
   // private direction and output registers
   // ------------------------------------------------------------
   logic [NPIN-1:0] dir_reg [NCORE];
   logic [NPIN-1:0] out_reg [NCORE];

   for (genvar k = 0; k < NCORE; k++) begin : g_regs
      logic sel;
      assign sel = apb_wr && (a_core == CORE_W'(k));
      always_ff @(posedge clk_i) begin
         if (rst_i || !core_run_i[k]) begin
            dir_reg[k] <= '0;
            out_reg[k] <= '0;
         end else begin
            if (sel && a_idx == IDX_DIR) begin
               dir_reg[k] <= pwdata_i;
            end
            if (sel && a_idx == IDX_OUT) begin
               out_reg[k] <= pwdata_i;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // pin combiner
   // ------------------------------------------------------------
   logic [NPIN-1:0] pin_meta;
   logic [NPIN-1:0] pin_sync;
   logic [NPIN-1:0] dir_or;
   logic [NPIN-1:0] out_or;

   always_ff @(posedge clk_i) begin
      pin_meta <= pin_i;
      pin_sync <= pin_meta;
   end

   always_comb begin
      dir_or = '0;
      out_or = '0;
      for (int k = 0; k < NCORE; k++) begin
         if (core_run_i[k]) begin
            dir_or = dir_or | dir_reg[k];
            out_or = out_or | ((core_pinsrc_i[k].ctr_a |
                                core_pinsrc_i[k].ctr_b |
                                core_pinsrc_i[k].video |
                                out_reg[k]) & dir_reg[k]);
         end
      end
   end

   // any core, any pin: wired-or needs no arbiter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_o <= '0;
         pin_oe_n_o <= '1;
      end else begin
         pin_o <= out_or;
         pin_oe_n_o <= ~dir_or;
      end
   end

   // ------------------------------------------------------------
   // apb answer: data prepared in setup, pready in first access
   // ------------------------------------------------------------
   logic [31:0] rd_mux;

   always_comb begin
      unique case (a_idx)
         IDX_COUNT: rd_mux = sys_count;
         IDX_INPUT: rd_mux = pin_sync;
         IDX_OUT: rd_mux = out_reg[a_core];
         IDX_DIR: rd_mux = dir_reg[a_core];
         default: rd_mux = RD_ZERO;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= RD_ZERO;
      end else begin
         pready_o <= psel_i && !penable_i;
         pslverr_o <= psel_i && !penable_i && a_bad;
         if (psel_i && !penable_i) begin
            prdata_o <= a_bad ? RD_ZERO : rd_mux;
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   // sync reset reaches disable iff one edge late: mask that edge too
   logic rst_late;

   always_ff @(posedge clk_i) begin
      rst_late <= rst_i;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || rst_late);

   a_count_step: assert property (
      ##1 sys_count == $past(sys_count) + 1'b1)
      else $error("system counter did not step by one");

   a_count_wrap: assert property (
      sys_count == '1 |=> sys_count == '0)
      else $error("system counter did not wrap to zero");

   a_half_rate: assert property (
      hub_en_o |=> !hub_en_o ##1 hub_en_o)
      else $error("hub enable not at half rate");

   a_slot_rotate: assert property (
      hub_slot_o == 3'h7 && !hub_en_o |=> hub_slot_o == '0)
      else $error("slot did not wrap from core 7 to 0");

   a_pin_dir: assert property (
      ##1 pin_oe_n_o == ~$past(dir_or))
      else $error("pin direction is not or of directions");

   a_pin_out: assert property (
      ##1 pin_o == $past(out_or))
      else $error("pin output mismatch");

   a_apb_ready: assert property (
      psel_i && !penable_i |=> pready_o)
      else $error("apb answer not in first access cycle");

   a_input_live: assert property (
      ##2 pin_sync == $past(pin_i, 2))
      else $error("input view is not the pins two cycles ago");

   for (genvar k = 0; k < NCORE; k++) begin : g_chk
      localparam logic [PHASE_W-1:0] WINC =
         PHASE_W'(k * int'(SLOT_CYC));

      a_grant_phase: assert property (
         core_grant_o[k] |-> phase == WINC + 1'b1)
         else $error("grant outside own window");

      a_hub_len: assert property (
         core_grant_o[k] |-> ##8 core_done_o[k])
         else $error("shared instruction not 8 cycles");

      a_hub_latency: assert property (
         state[k] == ST_IDLE && core_req_i[k].valid &&
         core_req_i[k].op != OP_PLAIN |=> ##[8:23] core_done_o[k])
         else $error("shared latency out of 8..23");

      a_plain_len: assert property (
         state[k] == ST_IDLE && core_req_i[k].valid &&
         core_req_i[k].op == OP_PLAIN |=> ##4 core_done_o[k])
         else $error("plain instruction not 4 cycles");

      a_halt_clear: assert property (
         !core_run_i[k] |=> dir_reg[k] == '0 && out_reg[k] == '0)
         else $error("halted core keeps pin state");

      a_done_clears: assert property (
         core_done_o[k] |-> !core_busy_o[k])
         else $error("busy still high with done");
   end

   c_all_busy: cover property (core_busy_o == '1);
   c_best_case: cover property (
      core_req_i[0].valid && state[0] == ST_IDLE && phase == '0);
   c_worst_case: cover property (
      core_req_i[0].valid && state[0] == ST_IDLE && phase == 4'h1);
   c_overlap: cover property (state[0] == ST_HUB && state[1] == ST_HUB);

endmodule : srh_hub

// >>> design/srh_pkg.sv
// constants and carrier types for the shared resource hub
package srh_pkg;

   // ------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------
   localparam int NCORE = 8;
   localparam int NPIN = 32;
   localparam int CORE_W = 3;
   localparam int PHASE_W = 4;
   localparam int CNT_W = 32;

   // ------------------------------------------------------------
   // timing: clock period in ns, the rest counted in system clock cycles
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam logic [PHASE_W-1:0] ROT_LAST = 4'hF;
   localparam logic [PHASE_W-1:0] SLOT_CYC = 4'h2;
   localparam logic [PHASE_W-1:0] HUB_EXEC_CYC = 4'h8;
   localparam logic [PHASE_W-1:0] PLAIN_EXEC_CYC = 4'h4;

   // ------------------------------------------------------------
   // special register array: printed locations and indices
   // ------------------------------------------------------------
   localparam logic [8:0] SPR_BASE = 9'h1F0;
   localparam logic [3:0] IDX_BOOT = 4'h0;
   localparam logic [3:0] IDX_COUNT = 4'h1;
   localparam logic [3:0] IDX_INPUT = 4'h2;
   localparam logic [3:0] IDX_OUT = 4'h4;
   localparam logic [3:0] IDX_DIR = 4'h6;
   localparam logic [3:0] IDX_LAST = 4'hF;

   // ------------------------------------------------------------
   // apb decode: byte address = core * 64 + index * 4
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int IDX_LSB = 2;
   localparam int CORE_LSB = 6;
   localparam int MAP_TOP = 9;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // ------------------------------------------------------------
   // instruction classes offered by a core
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_PLAIN = 4'h0,
      OP_CLOCK_CONFIG_WRITE = 4'h1,
      OP_OWN_CORE_INDEX = 4'h2,
      OP_CORE_LAUNCH = 4'h3,
      OP_CORE_HALT = 4'h4,
      OP_GENERIC_SHARED = 4'h5,
      OP_LOCK_CLEAR = 4'h6,
      OP_LOCK_ALLOCATE = 4'h7,
      OP_LOCK_RELEASE = 4'h8,
      OP_LOCK_TAKE = 4'h9,
      OP_READ8 = 4'hA,
      OP_READ16 = 4'hB,
      OP_READ32 = 4'hC,
      OP_WRITE8 = 4'hD,
      OP_WRITE16 = 4'hE,
      OP_WRITE32 = 4'hF
   } srh_op_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_HUB = 2'b10,
      ST_PLAIN = 2'b11
   } srh_state_e;

   typedef struct packed {
      logic valid;
      srh_op_e op;
   } srh_req_s;

   typedef struct packed {
      logic [NPIN-1:0] ctr_a;
      logic [NPIN-1:0] ctr_b;
      logic [NPIN-1:0] video;
   } srh_pinsrc_s;

endpackage : srh_pkg

// >>> tb/srh_cores.sv
// behavioural model of the eight cores that issue hub requests
`timescale 1ns/1ps
module srh_cores
   import srh_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [NCORE-1:0] go_i,
   input wire srh_op_e op_i,
   input wire logic [NCORE-1:0] done_i,
   output srh_req_s [NCORE-1:0] req_o,
   output logic [NCORE-1:0] wait_o,
   output int lat_o [NCORE]
);
   int cnt [NCORE];

   // ------------------------------------------------------------
   // one outstanding request per core, latency from taking edge
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      for (int k = 0; k < NCORE; k++) begin
         cnt[k] <= cnt[k] + 1;
         req_o[k].valid <= 1'b0;
         if (req_o[k].valid)
            cnt[k] <= 0;
         // no new request until the previous one is done
         if (go_i[k] && !wait_o[k]) begin
            req_o[k] <= '{1'b1, op_i};
            wait_o[k] <= 1'b1;
         end
         if (done_i[k] && wait_o[k]) begin
            lat_o[k] <= cnt[k];
            wait_o[k] <= 1'b0;
         end
         if (rst_i) begin
            req_o[k] <= '0;
            wait_o[k] <= 1'b0;
            cnt[k] <= 0;
         end
      end
   end
endmodule : srh_cores

// >>> tb/tb.sv
// self-checking bench for the shared resource hub
`timescale 1ns/1ps
module tb;
   import srh_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [NCORE-1:0] core_run = '1;
   srh_req_s [NCORE-1:0] core_req;
   srh_pinsrc_s [NCORE-1:0] pinsrc = '0;
   logic [NCORE-1:0] done;
   logic hub_en;
   logic [CORE_W-1:0] hub_slot;
   logic [CNT_W-1:0] sys_count;
   logic [NPIN-1:0] pin_i = '0;
   logic [NPIN-1:0] pin_o;
   logic [NPIN-1:0] pin_oe_n;
   logic [NCORE-1:0] go = '0;
   srh_op_e op = OP_PLAIN;
   logic [NCORE-1:0] wait_c;
   int lat [NCORE];
   int n_fail = 0;
   int tests_run = 0;
   logic [31:0] q;
   logic e;
   logic [31:0] c0;
   logic [31:0] seen;
   logic e0;
   int n;

   always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

   srh_hub i_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .core_run_i(core_run), .core_req_i(core_req),
      .core_pinsrc_i(pinsrc), .core_grant_o(), .core_done_o(done),
      .core_busy_o(), .hub_en_o(hub_en), .hub_slot_o(hub_slot),
      .sys_count_o(sys_count), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe_n_o(pin_oe_n));

   srh_cores i_cores (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
      .op_i(op), .done_i(done), .req_o(core_req), .wait_o(wait_c),
      .lat_o(lat));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic print_verdict();
      if (n_fail == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input string nm, input logic [31:0] x,
      input logic [31:0] g);
      tests_run++;
      if (g !== x) begin
         n_fail++;
         $display("mismatch %s exp %h got %h", nm, x, g);
      end
   endtask : chk

   function automatic logic [ADDR_W-1:0] ad(input int c, input int i);
      return ADDR_W'(c * 64 + i * 4);
   endfunction : ad

   // holds the whole request until pready is sampled high
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready !== 1'b1 && k < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50)
         n_fail++;
   endtask : apb

   task automatic issue(input logic [NCORE-1:0] m, input srh_op_e o);
      int k;
      k = 0;
      @(posedge clk_i);
      op <= o;
      go <= m;
      @(posedge clk_i);
      go <= '0;
      @(negedge clk_i);
      while (wait_c !== '0 && k < 60) begin
         @(negedge clk_i);
         k++;
      end
      if (k >= 60)
         n_fail++;
   endtask : issue

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      #(CLK_PERIOD_NS * 20000);
      n_fail++;
      print_verdict();
   end

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk("oe_n", '1, pin_oe_n);
      chk("pin", '0, pin_o);
      c0 = sys_count;
      e0 = hub_en;
      repeat (8) begin
         @(negedge clk_i);
         e0 = ~e0;
         chk("hub_en", {31'h0, e0}, {31'h0, hub_en});
      end
      chk("count", c0 + 32'h8, sys_count);
      c0 = sys_count;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk("count_rst", c0 + 32'h4, sys_count);
      apb(1'b1, ad(0, IDX_DIR), 32'h0000_F0F0);
      apb(1'b1, ad(0, IDX_OUT), 32'h0000_FF00);
      apb(1'b1, ad(1, IDX_DIR), 32'h000F_0000);
      pinsrc[0].ctr_b <= 32'h0000_0010;
      pinsrc[1].ctr_a <= 32'h0003_0000;
      pinsrc[2].video <= 32'h0000_000F;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk("oe_n", ~32'h000F_F0F0, pin_oe_n);
      chk("pin", 32'h0003_F010, pin_o);
      apb(1'b0, ad(0, IDX_OUT), '0);
      chk("out0", 32'h0000_FF00, q);
      apb(1'b0, ad(1, IDX_OUT), '0);
      chk("out1", '0, q);
      core_run[0] <= 1'b0;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk("oe_n", ~32'h000F_0000, pin_oe_n);
      chk("pin", 32'h0003_0000, pin_o);
      apb(1'b0, ad(0, IDX_DIR), '0);
      chk("dir0", '0, q);
      core_run[0] <= 1'b1;
      pin_i <= 32'hA5C3_0F1E;
      repeat (3) @(posedge clk_i);
      apb(1'b0, ad(5, IDX_INPUT), '0);
      chk("input", 32'hA5C3_0F1E, q);
      apb(1'b0, 12'h200, '0);
      chk("err", 32'h1, {31'h0, e});
      // every op class, on one core
      for (int i = 0; i < 16; i++) begin
         issue(8'h08, srh_op_e'(i));
         if (i == 0)
            chk("plain", 32'h4, lat[3]);
         else
            chk("shared", 32'h1, {31'h0, lat[3] >= 8 && lat[3] <= 23});
      end
      // all cores at once, one extra cycle of offset per round
      seen = '0;
      for (int j = 0; j < 16; j++) begin
         n = 0;
         while (hub_slot !== 3'h7 && n < 40) begin
            @(negedge clk_i);
            n++;
         end
         while (hub_slot !== 3'h0 && n < 40) begin
            @(negedge clk_i);
            n++;
         end
         if (n >= 40)
            n_fail++;
         repeat (j) @(posedge clk_i);
         issue('1, OP_READ32);
         for (int k = 1; k < NCORE; k++)
            chk("slot", 2 * k, (lat[k] - lat[0]) & 15);
         if (lat[0] >= 0 && lat[0] < 32)
            seen[lat[0]] = 1'b1;
      end
      chk("spread", 32'h00FF_FF00, seen);
      print_verdict();
   end
endmodule : tb
